// *** hdl/cdr_cfg_slave.sv ***
// Two-wire config slave with reference-mode control and rate measurement
//
// Contract
// - Answer address 1, select pin, 00000
// - Address byte LSB: 1 read, 0 write
// - Start begins transfer; bits MSB first
// - Ack on match; else release, go idle
// - Second byte is register subaddress, 8 regs
// - Pointer auto-advances after each data byte
// - Start or stop anywhere forces idle/restart
// - Master: one start/stop per SCL high
// - Invalid subaddress: no ack, go idle
// - Read past top repeats highest register
// - Master ends read with nack, stop
// - Control bit 0 enables lock-to-reference
// - Control bit 1 enables fine measurement, level
// - Host never sets both enables together
// - Bits 7:6 select reference band
// - Bits 5:2 set ratio two-power-n
// - Lock lost in reference mode: reacquire
// - Host retoggles lock enable after changes
// - Bit3 one-then-zero clears done, restarts measure
// - Done reads 0 busy, 1 valid
// - 23-bit result over three registers
// - Fine measure leaves lock behaviour alone
// - Host trusts result only without lock loss
//
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
module cdr_cfg_slave
	import cdr_cfg_pkg::*;
#(
	parameter int unsigned MEAS_CYCLES_P = MEAS_CYCLES
)
(
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	// Serial link
	two_wire_if.device      bus,
	// Device pins
	input  wire logic       i_address_select_pin,
	input  wire logic       i_lock_lost,
	input  wire logic       i_data_tick,
	// Reference-clock control
	output logic            o_lock_ref_en,
	output logic            o_fine_meas_en,
	output logic [1:0]      o_ref_range,
	output logic [3:0]      o_lock_ratio,
	output logic            o_lock_cmd,
	output logic            o_reacquire,
	output logic            o_meas_done
);

	localparam int unsigned MW = $clog2(MEAS_CYCLES_P + 1);

	slave_state_e      state_q;
	logic              scl_q;
	logic              sda_q;
	logic [3:0]        cnt_q;
	logic [7:0]        shift_q;
	logic [2:0]        ptr_q;
	logic              rw_q;
	logic              sda_oe_q;
	logic [7:0]        reg_q [8];
	logic [7:0]        live [8];
	logic              start_w;
	logic              stop_w;
	logic              rise_w;
	logic              fall_w;
	logic              addr_ok;
	logic              wr_stb;
	logic [2:0]        ptr_inc;
	logic              lock_lost_q;
	logic              lock_cmd_q;
	logic              reacq_q;
	logic              meas_start;
	logic              meas_end;
	logic              meas_act_q;
	logic [MW-1:0]     meas_cnt_q;
	logic [RATE_W-1:0] tick_cnt_q;
	logic [RATE_W-1:0] result_q;
	logic              done_q;

	// ----------------------------------------------------------------
	// Line events
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= bus.scl;
			sda_q <= bus.sda;
		end
	end

	assign start_w = scl_q & bus.scl & sda_q & ~bus.sda;
	assign stop_w  = scl_q & bus.scl & ~sda_q & bus.sda;
	assign rise_w  = ~scl_q & bus.scl;
	assign fall_w  = scl_q & ~bus.scl;
	assign addr_ok = shift_q[7:1] ==
		{DEV_ADDR_MSB, i_address_select_pin, DEV_ADDR_LOW};
	assign ptr_inc = (ptr_q == SUB_LAST) ? ptr_q : ptr_q + 3'h1;
	assign wr_stb  = (state_q == ST_WDATA) & fall_w & (cnt_q == 4'h8)
		& ~start_w & ~stop_w;

	// ----------------------------------------------------------------
	// Protocol engine
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state_q  <= ST_IDLE;
			cnt_q    <= 4'h0;
			shift_q  <= 8'h00;
			ptr_q    <= 3'h0;
			rw_q     <= 1'b0;
			sda_oe_q <= 1'b0;
		end
		else if (start_w)
		begin
			state_q  <= ST_ADDR;
			cnt_q    <= 4'h0;
			sda_oe_q <= 1'b0;
		end
		else if (stop_w)
		begin
			state_q  <= ST_IDLE;
			sda_oe_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
				begin
				end
				ST_ADDR, ST_SUB, ST_WDATA:
				begin
					if (rise_w)
					begin
						shift_q <= {shift_q[6:0], bus.sda};
						cnt_q   <= cnt_q + 4'h1;
					end
					else if (fall_w && cnt_q == 4'h8)
					begin
						cnt_q <= 4'h0;
						if (state_q == ST_ADDR)
						begin
							if (addr_ok)
							begin
								sda_oe_q <= 1'b1;
								rw_q     <= shift_q[0];
								state_q  <= ST_ADDR_ACK;
							end
							else
								state_q <= ST_IDLE;
						end
						else if (state_q == ST_SUB)
						begin
							if (shift_q < SUB_LIMIT)
							begin
								ptr_q    <= shift_q[2:0];
								sda_oe_q <= 1'b1;
								state_q  <= ST_SUB_ACK;
							end
							else
								state_q <= ST_IDLE;
						end
						else
						begin
							sda_oe_q <= 1'b1;
							state_q  <= ST_WACK;
						end
					end
				end
				ST_ADDR_ACK, ST_SUB_ACK, ST_WACK:
				begin
					if (fall_w)
					begin
						if (state_q == ST_ADDR_ACK && rw_q)
						begin
							shift_q  <= reg_q[ptr_q];
							sda_oe_q <= ~reg_q[ptr_q][7];
							state_q  <= ST_RDATA;
						end
						else
						begin
							sda_oe_q <= 1'b0;
							state_q  <= (state_q == ST_ADDR_ACK) ?
								ST_SUB : ST_WDATA;
						end
						if (state_q == ST_WACK)
							ptr_q <= ptr_inc;
					end
				end
				ST_RDATA:
				begin
					if (rise_w)
						cnt_q <= cnt_q + 4'h1;
					else if (fall_w)
					begin
						if (cnt_q == 4'h8)
						begin
							cnt_q    <= 4'h0;
							sda_oe_q <= 1'b0;
							state_q  <= ST_RACK;
						end
						else
						begin
							sda_oe_q <= ~shift_q[6];
							shift_q  <= {shift_q[6:0], 1'b0};
						end
					end
				end
				ST_RACK:
				begin
					if (rise_w)
					begin
						if (bus.sda)
							state_q <= ST_IDLE;
						else
							ptr_q <= ptr_inc;
					end
					else if (fall_w)
					begin
						shift_q  <= reg_q[ptr_q];
						sda_oe_q <= ~reg_q[ptr_q][7];
						state_q  <= ST_RDATA;
					end
				end
			endcase
		end
	end

	assign bus.dev_sda_o  = 1'b0;
	assign bus.dev_sda_oe = sda_oe_q;

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int k = 0; k < 8; k++)
			live[k] = 8'h00;
		live[SUB_STATUS][DONE_BIT]      = done_q;
		live[SUB_STATUS][LOCK_LOST_BIT] = lock_lost_q;
		live[SUB_RATE_HI]  = {1'b0, result_q[22:16]};
		live[SUB_RATE_MID] = result_q[15:8];
		live[SUB_RATE_LO]  = result_q[7:0];
	end

	// Read-only entries mirror live state one cycle late
	for (genvar i = 0; i < 8; i++)
	begin : g_reg
		always_ff @(posedge i_clk or negedge i_rst_b)
		begin
			if (!i_rst_b)
				reg_q[i] <= REG_RESET;
			else if (!RW_MASK[i])
				reg_q[i] <= live[i];
			else if (wr_stb && ptr_q == 3'(i))
				reg_q[i] <= shift_q;
		end
	end

	assign o_lock_ref_en  = reg_q[SUB_REF_MODE][LOCK_EN_BIT];
	assign o_fine_meas_en = reg_q[SUB_REF_MODE][FINE_EN_BIT];
	assign o_ref_range    = reg_q[SUB_REF_MODE][RANGE_LSB +: 2];
	assign o_lock_ratio   = reg_q[SUB_REF_MODE][RATIO_LSB +: 4];

	// ----------------------------------------------------------------
	// Lock-to-reference commands
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			lock_lost_q <= 1'b0;
			lock_cmd_q  <= 1'b0;
			reacq_q     <= 1'b0;
		end
		else
		begin
			lock_lost_q <= i_lock_lost;
			// Only a 0-to-1 write on the enable issues a new lock
			lock_cmd_q  <= wr_stb && ptr_q == SUB_REF_MODE
				&& !reg_q[SUB_REF_MODE][LOCK_EN_BIT]
				&& shift_q[LOCK_EN_BIT];
			// Independent of the fine enable
			reacq_q     <= reg_q[SUB_REF_MODE][LOCK_EN_BIT]
				& i_lock_lost & ~lock_lost_q;
		end
	end

	assign o_lock_cmd  = lock_cmd_q;
	assign o_reacquire = reacq_q;

	// ----------------------------------------------------------------
	// Fine rate measurement
	// ----------------------------------------------------------------
	assign meas_start = wr_stb && ptr_q == SUB_CTRL_B
		&& reg_q[SUB_CTRL_B][MEAS_RST_BIT] && !shift_q[MEAS_RST_BIT]
		&& reg_q[SUB_REF_MODE][FINE_EN_BIT];
	assign meas_end = meas_act_q
		&& meas_cnt_q == MW'(MEAS_CYCLES_P - 1);

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			meas_act_q <= 1'b0;
			meas_cnt_q <= '0;
			tick_cnt_q <= '0;
			result_q   <= '0;
		end
		else if (meas_end)
		begin
			meas_act_q <= 1'b0;
			result_q   <= tick_cnt_q;
		end
		else if (meas_start)
		begin
			meas_act_q <= 1'b1;
			meas_cnt_q <= '0;
			tick_cnt_q <= '0;
		end
		else if (meas_act_q)
		begin
			meas_cnt_q <= meas_cnt_q + MW'(1);
			if (i_data_tick && tick_cnt_q != {RATE_W{1'b1}})
				tick_cnt_q <= tick_cnt_q + RATE_W'(1);
		end
	end

	// Finish beats a same-cycle restart
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			done_q <= 1'b0;
		else if (meas_end)
			done_q <= 1'b1;
		else if (meas_start)
			done_q <= 1'b0;
	end

	assign o_meas_done = done_q;

endmodule

// *** shared/cdr_cfg_pkg.sv ***
// Constants and state types shared by the two-wire config master and slave
package cdr_cfg_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ      = 250;
	localparam int unsigned MEAS_TIME_US = 80000;
	localparam int unsigned MEAS_CYCLES  = MEAS_TIME_US * CLK_MHZ;
	localparam int unsigned BUS_RATE_KHZ = 100;
	// Quarter of one serial clock period, rounded down
	localparam int unsigned QTR_CYCLES   = (CLK_MHZ * 1000) / (4 * BUS_RATE_KHZ);

	// ----------------------------------------------------------------
	// Slave address and register map
	// ----------------------------------------------------------------
	localparam logic       DEV_ADDR_MSB = 1'b1;
	localparam logic [4:0] DEV_ADDR_LOW = 5'h00;
	localparam logic [7:0] SUB_LIMIT    = 8'h08;
	localparam logic [2:0] SUB_REF_MODE = 3'h0;
	localparam logic [2:0] SUB_CTRL_B   = 3'h1;
	localparam logic [2:0] SUB_STATUS   = 3'h2;
	localparam logic [2:0] SUB_RATE_HI  = 3'h3;
	localparam logic [2:0] SUB_RATE_MID = 3'h4;
	localparam logic [2:0] SUB_RATE_LO  = 3'h5;
	localparam logic [2:0] SUB_LAST     = 3'h7;
	localparam logic [7:0] RW_MASK      = 8'hC3;
	localparam logic [7:0] REG_RESET    = 8'h00;
	localparam int unsigned RATE_W      = 23;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned LOCK_EN_BIT   = 0;
	localparam int unsigned FINE_EN_BIT   = 1;
	localparam int unsigned RATIO_LSB     = 2;
	localparam int unsigned RANGE_LSB     = 6;
	localparam int unsigned MEAS_RST_BIT  = 3;
	localparam int unsigned DONE_BIT      = 2;
	localparam int unsigned LOCK_LOST_BIT = 0;

	// ----------------------------------------------------------------
	// Controller registers on the Avalon side
	// ----------------------------------------------------------------
	localparam logic [3:0] AV_CMD        = 4'h0;
	localparam logic [3:0] AV_STATUS     = 4'h4;
	localparam logic [3:0] AV_TARGET     = 4'h8;
	localparam int unsigned CMD_SUB_LSB  = 8;
	localparam int unsigned CMD_READ_BIT = 16;
	localparam int unsigned ST_NACK_BIT  = 1;
	localparam int unsigned ST_RDATA_LSB = 8;
	localparam logic [6:0] TARGET_RESET  = 7'h40;

	// ----------------------------------------------------------------
	// State types
	// ----------------------------------------------------------------
	typedef enum logic [8:0] {
		ST_IDLE     = 9'h001,
		ST_ADDR     = 9'h002,
		ST_ADDR_ACK = 9'h004,
		ST_SUB      = 9'h008,
		ST_SUB_ACK  = 9'h010,
		ST_WDATA    = 9'h020,
		ST_WACK     = 9'h040,
		ST_RDATA    = 9'h080,
		ST_RACK     = 9'h100
	} slave_state_e;

	typedef enum logic [3:0] {
		H_IDLE  = 4'h1,
		H_START = 4'h2,
		H_BYTE  = 4'h4,
		H_STOP  = 4'h8
	} master_state_e;

endpackage

// *** shared/two_wire_if.sv ***
// Open-drain two-wire link between the config master and the slave
`timescale 1ns/1ps
interface two_wire_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// Pull-ups win unless an enabled driver pulls low
	assign scl = ~(host_scl_oe & ~host_scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport host
	(
		output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
		input  scl, sda
	);
	modport device
	(
		output dev_sda_o, dev_sda_oe,
		input  scl, sda
	);
endinterface

// *** hdl/cdr_cfg_master.sv ***
// Two-wire config master driven by Avalon-MM command registers
`timescale 1ns/1ps
module cdr_cfg_master
	import cdr_cfg_pkg::*;
#(
	parameter int unsigned QTR_CYCLES_P = QTR_CYCLES
)
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	// Avalon-MM slave
	input  wire logic [3:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest,
	// Serial link
	two_wire_if.host         bus
);

	master_state_e state_q;
	logic          wait_q;
	logic [31:0]   rdata_q;
	logic [6:0]    target_q;
	logic [7:0]    wdat_q;
	logic [7:0]    sub_q;
	logic          rd_q;
	logic [15:0]   div_q;
	logic          tick;
	logic [1:0]    phase_q;
	logic [3:0]    bit_q;
	logic [2:0]    step_q;
	logic [7:0]    txb_q;
	logic [7:0]    rxb_q;
	logic          nack_q;
	logic          scl_oe_q;
	logic          sda_oe_q;
	logic          go;
	logic          busy;
	logic          rd_byte;
	logic [2:0]    last_step;

	function automatic logic [7:0] byte_for(input logic [2:0] s);
		unique case (s)
			3'h1:    byte_for = {target_q, 1'b0};
			3'h2:    byte_for = sub_q;
			3'h3:    byte_for = rd_q ? {target_q, 1'b1} : wdat_q;
			default: byte_for = 8'hFF;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Avalon slave: answer on the second edge of a request
	// ----------------------------------------------------------------
	assign busy = state_q != H_IDLE;
	assign go   = i_avs_write && !wait_q && i_avs_address == AV_CMD && !busy;

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			wait_q <= !((i_avs_read || i_avs_write) && wait_q);
			if (i_avs_read && wait_q)
			begin
				rdata_q <= 32'h0000_0000;
				if (i_avs_address == AV_STATUS)
				begin
					rdata_q[0]                <= busy;
					rdata_q[ST_NACK_BIT]      <= nack_q;
					rdata_q[ST_RDATA_LSB +: 8] <= rxb_q;
				end
				else if (i_avs_address == AV_TARGET)
					rdata_q[6:0] <= target_q;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			target_q <= TARGET_RESET;
			wdat_q   <= 8'h00;
			sub_q    <= 8'h00;
			rd_q     <= 1'b0;
		end
		else if (go)
		begin
			wdat_q <= i_avs_writedata[7:0];
			sub_q  <= i_avs_writedata[CMD_SUB_LSB +: 8];
			rd_q   <= i_avs_writedata[CMD_READ_BIT];
		end
		else if (i_avs_write && !wait_q && i_avs_address == AV_TARGET)
			target_q <= i_avs_writedata[6:0];
	end

	assign o_avs_readdata    = rdata_q;
	assign o_avs_waitrequest = wait_q;

	// ----------------------------------------------------------------
	// Bit timing: four quarter phases per serial clock
	// ----------------------------------------------------------------
	assign tick = div_q == 16'(QTR_CYCLES_P - 1);

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			div_q <= 16'h0000;
		else if (!busy || tick)
			div_q <= 16'h0000;
		else
			div_q <= div_q + 16'h0001;
	end

	assign rd_byte   = rd_q && step_q == 3'h4;
	assign last_step = rd_q ? 3'h4 : 3'h3;

	// ----------------------------------------------------------------
	// Transfer sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state_q  <= H_IDLE;
			phase_q  <= 2'h0;
			bit_q    <= 4'h0;
			step_q   <= 3'h0;
			txb_q    <= 8'h00;
			rxb_q    <= 8'h00;
			nack_q   <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end
		else if (go)
		begin
			state_q <= H_START;
			phase_q <= 2'h0;
			step_q  <= 3'h0;
			nack_q  <= 1'b0;
		end
		else if (tick)
		begin
			phase_q <= phase_q + 2'h1;
			unique case (state_q)
				H_IDLE:
				begin
				end
				H_START:
				begin
					// One start per high period of the clock
					unique case (phase_q)
						2'h0: sda_oe_q <= 1'b0;
						2'h1: scl_oe_q <= 1'b0;
						2'h2: sda_oe_q <= 1'b1;
						2'h3:
						begin
							scl_oe_q <= 1'b1;
							state_q  <= H_BYTE;
							bit_q    <= 4'h0;
							step_q   <= step_q + 3'h1;
							txb_q    <= byte_for(step_q + 3'h1);
						end
					endcase
				end
				H_BYTE:
				begin
					unique case (phase_q)
						2'h0: sda_oe_q <= (bit_q < 4'h8 && !rd_byte)
							? ~txb_q[7] : 1'b0;
						2'h1: scl_oe_q <= 1'b0;
						2'h2:
						begin
							if (bit_q < 4'h8)
								rxb_q <= {rxb_q[6:0], bus.sda};
							else if (!rd_byte && bus.sda)
								nack_q <= 1'b1;
						end
						2'h3:
						begin
							scl_oe_q <= 1'b1;
							if (bit_q < 4'h8)
							begin
								bit_q <= bit_q + 4'h1;
								txb_q <= {txb_q[6:0], 1'b0};
							end
							else
							begin
								bit_q <= 4'h0;
								if (nack_q || step_q == last_step)
									state_q <= H_STOP;
								else if (rd_q && step_q == 3'h2)
									state_q <= H_START;
								else
								begin
									step_q <= step_q + 3'h1;
									txb_q  <= byte_for(step_q + 3'h1);
								end
							end
						end
					endcase
				end
				H_STOP:
				begin
					unique case (phase_q)
						2'h0: sda_oe_q <= 1'b1;
						2'h1: scl_oe_q <= 1'b0;
						2'h2: sda_oe_q <= 1'b0;
						2'h3: state_q  <= H_IDLE;
					endcase
				end
			endcase
		end
	end

	assign bus.host_scl_o  = 1'b0;
	assign bus.host_scl_oe = scl_oe_q;
	assign bus.host_sda_o  = 1'b0;
	assign bus.host_sda_oe = sda_oe_q;

endmodule

// *** test/cdr_cfg_checker.sv ***
// Assertions on the two-wire link joining the config master and slave
`timescale 1ns/1ps
module cdr_cfg_checker
(
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst_b,
	// Link drivers and resolved levels
	input  wire logic i_host_sda_oe,
	input  wire logic i_dev_sda_oe,
	input  wire logic i_scl,
	input  wire logic i_sda,
	// Slave strap
	input  wire logic i_address_select_pin
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);

	// ----------------
	// Bit tracking
	// ----------------
	logic       scl_q;
	logic       sda_q;
	logic [3:0] bit_q;
	logic [1:0] byte_q;
	logic [7:0] sh_q;
	logic       ok_q;
	logic       rd_q;
	logic       rise;
	logic       start;
	logic       stop;
	logic       ack;

	assign rise  = i_scl & ~scl_q;
	assign start = i_scl & scl_q & sda_q & ~i_sda;
	assign stop  = i_scl & scl_q & ~sda_q & i_sda;
	assign ack   = rise & (bit_q == 4'h8);

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= i_scl;
			sda_q <= i_sda;
		end
	end

	// Ok stays set only while every ack so far was given
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			bit_q  <= 4'h0;
			byte_q <= 2'h0;
			sh_q   <= 8'h00;
			ok_q   <= 1'b0;
			rd_q   <= 1'b0;
		end
		else if (start)
		begin
			bit_q  <= 4'h0;
			byte_q <= 2'h0;
			ok_q   <= 1'b0;
		end
		else if (ack)
		begin
			bit_q <= 4'h0;
			ok_q  <= ~i_sda & (ok_q | byte_q == 2'h0);
			if (byte_q == 2'h0)
				rd_q <= sh_q[0];
			if (byte_q != 2'h3)
				byte_q <= byte_q + 2'h1;
		end
		else if (rise)
		begin
			bit_q <= bit_q + 4'h1;
			sh_q  <= {sh_q[6:0], i_sda};
		end
	end

	// ----------------
	// Assertions
	// ----------------
	sda_on_low_a: assert property
		($changed(i_dev_sda_oe) |-> !i_scl)
		else $error("slave moved SDA while SCL high");
	addr_ack_a: assert property
		(ack && byte_q == 2'h0 |->
		(i_sda == 1'b0) ==
		(sh_q[7:1] == {1'b1, i_address_select_pin, 5'h00}))
		else $error("address acknowledge wrong");
	nack_idle_a: assert property
		(ack && byte_q == 2'h0 && i_sda |=> !i_dev_sda_oe [*8])
		else $error("slave drove SDA after address mismatch");
	sub_ack_a: assert property
		(ack && byte_q == 2'h1 && ok_q && !rd_q |->
		(i_sda == 1'b0) == (sh_q < 8'h08))
		else $error("subaddress acknowledge wrong");
	data_ack_a: assert property
		(ack && byte_q == 2'h2 && ok_q && !rd_q |-> i_sda == 1'b0)
		else $error("write data not acknowledged");
	start_quiet_a: assert property
		(start |=> !i_dev_sda_oe [*8])
		else $error("slave drove SDA right after start");
	stop_quiet_a: assert property
		(stop |=> !i_dev_sda_oe [*8])
		else $error("slave drove SDA right after stop");
	no_fight_a: assert property
		(i_scl |-> !(i_host_sda_oe && i_dev_sda_oe))
		else $error("both ends drive SDA");
endmodule

// *** test/test_i2c_config_and_rate_measure.sv ***
// Bench joining config master and slave, checked against a register model
`timescale 1ns/1ps
module test_i2c_config_and_rate_measure
	import cdr_cfg_pkg::*;
;
	// Short counts keep the run brief
	localparam int unsigned QTR  = 4;
	localparam int unsigned MEAS = 3000;

	logic        i_clk;
	logic        i_rst_b;
	logic [3:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        sel;
	logic        lock_lost;
	logic        data_tick;
	wire  [7:0]  mode;
	logic        lock_cmd;
	logic        reacquire;
	logic        meas_done;
	logic [6:0]  tgt;
	logic [7:0]  model [8];
	int          n_errors;
	int          samples_checked;
	int          n_cmd;
	int          n_reacq;
	int          e_cmd;
	int          seed;

	two_wire_if link ();

	cdr_cfg_master #(.QTR_CYCLES_P(QTR)) i_cdr_cfg_master
	(
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_avs_address(avs_address),
		.i_avs_read(avs_read),
		.i_avs_write(avs_write),
		.i_avs_writedata(avs_writedata),
		.o_avs_readdata(avs_readdata),
		.o_avs_waitrequest(avs_waitrequest),
		.bus(link.host)
	);

	cdr_cfg_slave #(.MEAS_CYCLES_P(MEAS)) i_cdr_cfg_slave
	(
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.bus(link.device),
		.i_address_select_pin(sel),
		.i_lock_lost(lock_lost),
		.i_data_tick(data_tick),
		.o_lock_ref_en(mode[0]),
		.o_fine_meas_en(mode[1]),
		.o_ref_range(mode[7:6]),
		.o_lock_ratio(mode[5:2]),
		.o_lock_cmd(lock_cmd),
		.o_reacquire(reacquire),
		.o_meas_done(meas_done)
	);

	cdr_cfg_checker i_cdr_cfg_checker
	(
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_host_sda_oe(link.host_sda_oe),
		.i_dev_sda_oe(link.dev_sda_oe),
		.i_scl(link.scl),
		.i_sda(link.sda),
		.i_address_select_pin(sel)
	);

	initial
	begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	always @(posedge i_clk)
	begin
		n_cmd   <= n_cmd + int'(lock_cmd === 1'b1);
		n_reacq <= n_reacq + int'(reacquire === 1'b1);
	end

	// ----------------
	// Tasks
	// ----------------
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Waitrequest and read data taken at one rising edge
	task automatic av(input logic [3:0] a, input logic wr,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge i_clk);
		avs_address   <= a;
		avs_write     <= wr;
		avs_read      <= ~wr;
		avs_writedata <= d;
		do
			@(posedge i_clk);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask

	task automatic reg_io(input logic rd, input logic [7:0] sub,
		input logic [7:0] d);
		logic [31:0] st;
		logic        bad;
		bad = sub > 8'h07 || tgt != {1'b1, sel, 5'h00};
		av(AV_CMD, 1'b1, {15'h0, rd, sub, d}, st);
		do
			av(AV_STATUS, 1'b0, 32'h0, st);
		while (st[0] !== 1'b0);
		chk("nack", {31'h0, bad}, {31'h0, st[ST_NACK_BIT]});
		if (rd && !bad)
			chk("read data", {24'h0, d}, {24'h0, st[ST_RDATA_LSB +: 8]});
		if (!rd && !bad && sub == 8'h00 && !model[0][0] && d[0])
			e_cmd++;
		if (!rd && !bad && RW_MASK[sub[2:0]])
			model[sub[2:0]] = d;
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		#400000;
		n_errors++;
		stop_test();
	end

	// ----------------
	// Scenarios
	// ----------------
	initial
	begin
		logic [31:0] q;
		logic [7:0]  v;
		logic [7:0]  s;
		int          cnt;
		int          e_rq;
		seed = 58563;
		n_errors = 0;
		samples_checked = 0;
		n_cmd = 0;
		n_reacq = 0;
		e_cmd = 0;
		e_rq = 0;
		tgt = TARGET_RESET;
		sel = 1'b0;
		lock_lost = 1'b0;
		data_tick = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		for (int i = 0; i < 8; i++)
			model[i] = REG_RESET;
		i_rst_b = 1'b0;
		repeat (8) @(posedge i_clk);
		i_rst_b <= 1'b1;
		av(AV_TARGET, 1'b0, 32'h0, q);
		chk("target reset", {25'h0, TARGET_RESET}, q);
		av(4'hC, 1'b0, 32'h0, q);
		chk("unmapped read", 32'h0, q);
		for (int i = 0; i < 8; i++)
			reg_io(1'b1, 8'(i), REG_RESET);
		// Address strap and target table, mismatches included
		for (int i = 0; i < 6; i++)
		begin
			sel <= i[1];
			tgt = (i < 4) ? {1'b1, i[0], 5'h00} : {~i[0], 5'h00, 1'b1};
			av(AV_TARGET, 1'b1, {25'h0, tgt}, q);
			reg_io(1'b0, 8'h06, 8'($random(seed)));
			reg_io(1'b1, 8'h06, model[6]);
		end
		sel <= 1'b1;
		tgt = 7'h60;
		av(AV_TARGET, 1'b1, 32'h60, q);
		// Both enables together is illegal, so never sent
		for (int i = 0; i < 16; i++)
		begin
			v = 8'($random(seed));
			s = {5'h0, 3'($random(seed))};
			if (s == 8'h01)
				v[3] = 1'b0;
			if (s == 8'h00 && v[1:0] == 2'b11)
				v[1] = 1'b0;
			reg_io(1'b0, s, v);
			reg_io(1'b1, s, model[s[2:0]]);
			chk("mode pins", {24'h0, model[0]}, {24'h0, mode});
			chk("lock command", e_cmd, n_cmd);
		end
		reg_io(1'b0, 8'h08, 8'h5A);
		reg_io(1'b1, 8'hFF, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			reg_io(1'b0, 8'h00, {7'h0, i < 3});
			lock_lost <= 1'b1;
			reg_io(1'b1, 8'h02, 8'h01);
			lock_lost <= 1'b0;
			e_rq += model[0][0];
			@(posedge i_clk);
		end
		chk("reacquire count", e_rq, n_reacq);
		chk("lock command", e_cmd, n_cmd);
		reg_io(1'b0, 8'h00, 8'h02);
		for (int i = 0; i < 2; i++)
		begin
			reg_io(1'b0, 8'h01, 8'h08);
			reg_io(1'b0, 8'h01, 8'h00);
			chk("done pin", 32'h0, {31'h0, meas_done});
			reg_io(1'b1, 8'h02, 8'h00);
			cnt = 0;
			repeat (64)
			begin
				@(posedge i_clk);
				v[0] = 1'($random(seed));
				data_tick <= v[0];
				cnt += v[0];
			end
			@(posedge i_clk);
			data_tick <= 1'b0;
			for (int w = 0; w < MEAS && meas_done !== 1'b1; w++)
				@(negedge i_clk);
			chk("done pin", 32'h1, {31'h0, meas_done});
			reg_io(1'b1, 8'h02, 8'h04);
			reg_io(1'b1, 8'h03, {1'b0, 7'(cnt >> 16)});
			reg_io(1'b1, 8'h04, 8'(cnt >> 8));
			reg_io(1'b1, 8'h05, 8'(cnt));
		end
		stop_test();
	end
endmodule
